// ===== rtl/ldfcl_core.sv
`timescale 1ns/100ps

`include "ldfcl_params.svh"

module ldfcl_core
    import ldfcl_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire logic                    serial_clock,
    input  wire logic                    serial_input,
    output logic                         serial_output,
    input  wire logic                    latch_strobe,
    input  wire logic                    blanking,
    input  wire logic [`LDFCL_CH_W-1:0]  open_led_flag,
    input  wire logic [`LDFCL_CH_W-1:0]  shorted_led_flag,
    input  wire logic [`LDFCL_CH_W-1:0]  output_leakage_flag,
    input  wire logic                    thermal_error_flag,
    input  wire logic                    prethermal_warning,
    input  wire logic                    ref_pin_short_flag,
    output logic      [`LDFCL_CH_W-1:0]  sink_channel,
    output logic      [6:0]              global_brightness_code,
    output logic      [1:0]              short_threshold_select,
    output logic      [1:0]              invisible_detect_current,
    output logic                         invisible_detection,
    output logic                         power_save
);

    // ============================================================
    // State
    typedef struct packed {
        logic                   lat_s1;
        logic                   lat_s2;
        logic                   lat_d;
        logic                   blank_s1;
        logic                   blank_s2;
        logic                   blank_d;
        logic                   edge_s1;
        logic                   edge_s2;
        logic                   edge_d;
        logic [`LDFCL_SR_W-1:0] word_s1;
        logic [`LDFCL_SR_W-1:0] word_s2;
        logic [`LDFCL_CH_W-1:0] open_s1;
        logic [`LDFCL_CH_W-1:0] open_s2;
        logic [`LDFCL_CH_W-1:0] short_s1;
        logic [`LDFCL_CH_W-1:0] short_s2;
        logic [`LDFCL_CH_W-1:0] leak_s1;
        logic [`LDFCL_CH_W-1:0] leak_s2;
        logic [2:0]             alarm_s1;
        logic [2:0]             alarm_s2;
        ldfcl_fc_t              fc;
        logic [`LDFCL_CH_W-1:0] onoff;
        logic [`LDFCL_CH_W-1:0] sinks;
        logic                   load_tog;
        logic [`LDFCL_CH_W-1:0] load_word;
        ldfcl_ps_state_t        ps;
        logic                   ps_flag;
    } ldfcl_core_st_t;

    ldfcl_core_st_t          core_reg;
    ldfcl_core_st_t          core_next;

    logic [`LDFCL_SR_W-1:0]  shift_word;
    logic                    edge_toggle;
    logic                    lat_rise;
    logic                    blank_rise;
    logic                    sclk_seen;
    logic                    ps_enter;
    logic                    idm_start;
    logic                    idm_busy;

    // ============================================================
    // Status selection
    // The alarm paired with the selected flag set (thermal error for open,
    // pre-thermal warning for short, ref-pin short for leakage) replaces
    // them with all ones, so software can tell it apart from channel faults.
    function automatic logic [`LDFCL_CH_W-1:0] status_pick(
        input logic [1:0]             sel,
        input logic [`LDFCL_CH_W-1:0] open_f,
        input logic [`LDFCL_CH_W-1:0] short_f,
        input logic [`LDFCL_CH_W-1:0] leak_f,
        input logic [2:0]             alarm
    );
        case (sel)
            `LDFCL_SLD_OPEN:
                status_pick = alarm[0] ? `LDFCL_ALL_ONES : open_f;
            `LDFCL_SLD_SHORT:
                status_pick = alarm[1] ? `LDFCL_ALL_ONES : short_f;
            `LDFCL_SLD_LEAK:
                status_pick = alarm[2] ? `LDFCL_ALL_ONES : leak_f;
            default:
                status_pick = `LDFCL_ALL_ZERO;
        endcase
    endfunction

    // ============================================================
    // Serial clock domain
    ldfcl_shift_link u_link (
        .serial_clock  (serial_clock),
        .rst_b         (rst_b),
        .serial_input  (serial_input),
        .load_toggle   (core_reg.load_tog),
        .load_word     (core_reg.load_word),
        .shift_word    (shift_word),
        .serial_output (serial_output),
        .edge_toggle   (edge_toggle)
    );

    // ============================================================
    // Invisible detection timer, paced by the reference clock
    ldfcl_idm_timer u_idm (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .start    (idm_start),
        .duration (core_reg.fc.invisible_detect_duration),
        .busy     (idm_busy),
        .done     ()
    );

    // ============================================================
    // Event detection on synchronised inputs
    assign lat_rise   = core_reg.lat_s2 & ~core_reg.lat_d;
    assign blank_rise = core_reg.blank_s2 & ~core_reg.blank_d;
    assign sclk_seen  = core_reg.edge_s2 ^ core_reg.edge_d;
    assign idm_start  = blank_rise &&
                        (core_reg.fc.invisible_detect_current
                         != `LDFCL_IDM_OFF);

    // ============================================================
    // Next state
    always_comb
    begin
        core_next          = core_reg;
        core_next.lat_s1   = latch_strobe;
        core_next.lat_s2   = core_reg.lat_s1;
        core_next.lat_d    = core_reg.lat_s2;
        core_next.blank_s1 = blanking;
        core_next.blank_s2 = core_reg.blank_s1;
        core_next.blank_d  = core_reg.blank_s2;
        core_next.edge_s1  = edge_toggle;
        core_next.edge_s2  = core_reg.edge_s1;
        core_next.edge_d   = core_reg.edge_s2;
        // The shift word is quasi-static: the host stops the serial
        // clock before raising the strobe, and the strobe itself takes
        // two more stages, so both copies have settled by then.
        core_next.word_s1  = shift_word;
        core_next.word_s2  = core_reg.word_s1;
        core_next.open_s1  = open_led_flag;
        core_next.open_s2  = core_reg.open_s1;
        core_next.short_s1 = shorted_led_flag;
        core_next.short_s2 = core_reg.short_s1;
        core_next.leak_s1  = output_leakage_flag;
        core_next.leak_s2  = core_reg.leak_s1;
        core_next.alarm_s1 = {ref_pin_short_flag, prethermal_warning,
                              thermal_error_flag};
        core_next.alarm_s2 = core_reg.alarm_s1;

        if (lat_rise)
        begin
            if (core_reg.word_s2[`LDFCL_SEL_BIT])
            begin
                // No status load here, so the shift path stays as is
                core_next.fc = ldfcl_fc_t'(
                    core_reg.word_s2[`LDFCL_CH_W-1:0]);
            end
            else
            begin
                core_next.onoff =
                    core_reg.word_s2[`LDFCL_CH_W-1:0];
                if (core_reg.fc.status_load_select
                    != `LDFCL_SLD_NONE)
                begin
                    core_next.load_word = status_pick(
                        core_reg.fc.status_load_select,
                        core_reg.open_s2,
                        core_reg.short_s2,
                        core_reg.leak_s2,
                        core_reg.alarm_s2);
                    core_next.load_tog  = ~core_reg.load_tog;
                end
            end
        end

        // Power-save: entered, when power_save_enable is set, by any strobe that
        // leaves the on/off latch all zero; a strobe beats a serial edge in one cycle.
        ps_enter = lat_rise && core_next.fc.power_save_enable &&
                   (core_next.onoff == `LDFCL_ALL_ZERO);
        case (core_reg.ps)
            LDFCL_PS_RUN:
            begin
                if (ps_enter)
                begin
                    core_next.ps = LDFCL_PS_SAVE;
                end
            end
            LDFCL_PS_SAVE:
            begin
                if (sclk_seen && !ps_enter)
                begin
                    core_next.ps = LDFCL_PS_RUN;
                end
            end
            default:
            begin
                core_next.ps = LDFCL_PS_RUN;
            end
        endcase
        core_next.ps_flag = (core_next.ps == LDFCL_PS_SAVE);

        core_next.sinks = core_reg.blank_s2 ? `LDFCL_ALL_ZERO
                                            : core_reg.onoff;
    end

    // ============================================================
    // Registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            core_reg       <= '0;
            core_reg.fc    <= `LDFCL_FC_RESET;
            core_reg.ps    <= LDFCL_PS_RUN;
        end
        else
        begin
            core_reg <= core_next;
        end
    end

    // ============================================================
    // Outputs, all straight from flip-flops
    assign sink_channel             = core_reg.sinks;
    assign global_brightness_code   =
        core_reg.fc.global_brightness_code;
    assign short_threshold_select   =
        core_reg.fc.short_threshold_select;
    assign invisible_detect_current =
        core_reg.fc.invisible_detect_current;
    assign invisible_detection      = idm_busy;
    assign power_save               = core_reg.ps_flag;

endmodule

// ===== rtl/ldfcl_params.svh
`ifndef LDFCL_PARAMS_SVH
`define LDFCL_PARAMS_SVH

// ============================================================
// Widths
`define LDFCL_SR_W        17
`define LDFCL_CH_W        16
`define LDFCL_SEL_BIT     16
`define LDFCL_CNT_W       8

// ============================================================
// Reset values
`define LDFCL_FC_RESET    16'he67f
`define LDFCL_SR_RESET    17'h00000
`define LDFCL_ALL_ZERO    16'h0000
`define LDFCL_ALL_ONES    16'hffff

// ============================================================
// Status load select codes
`define LDFCL_SLD_NONE    2'h0
`define LDFCL_SLD_OPEN    2'h1
`define LDFCL_SLD_SHORT   2'h2
`define LDFCL_SLD_LEAK    2'h3

// ============================================================
// Invisible detection current and on-time, in timebase periods
`define LDFCL_IDM_OFF     2'h0
`define LDFCL_IDM_T0      8'h11
`define LDFCL_IDM_T1      8'h21
`define LDFCL_IDM_T2      8'h41
`define LDFCL_IDM_T3      8'h81
`define LDFCL_CNT_LAST    8'h01

`endif

// ===== rtl/ldfcl_pkg.sv
package ldfcl_pkg;

`include "ldfcl_params.svh"

    // ============================================================
    // Function control word layout, bit 15 down to bit 0
    typedef struct packed {
        logic       power_save_enable;
        logic [1:0] invisible_detect_duration;
        logic [1:0] invisible_detect_current;
        logic [1:0] short_threshold_select;
        logic [1:0] status_load_select;
        logic [6:0] global_brightness_code;
    } ldfcl_fc_t;

    typedef enum logic [1:0] {
        LDFCL_PS_RUN  = 2'b01,
        LDFCL_PS_SAVE = 2'b10
    } ldfcl_ps_state_t;

    typedef enum logic [1:0] {
        LDFCL_IDM_IDLE = 2'b01,
        LDFCL_IDM_RUN  = 2'b10
    } ldfcl_idm_state_t;

endpackage

// ===== rtl/ldfcl_shift_link.sv
`timescale 1ns/100ps

`include "ldfcl_params.svh"

module ldfcl_shift_link
    import ldfcl_pkg::*;
(
    input  wire logic                    serial_clock,
    input  wire logic                    rst_b,
    input  wire logic                    serial_input,
    input  wire logic                    load_toggle,
    input  wire logic [`LDFCL_CH_W-1:0]  load_word,
    output logic      [`LDFCL_SR_W-1:0]  shift_word,
    output logic                         serial_output,
    output logic                         edge_toggle
);

    typedef struct packed {
        logic [`LDFCL_SR_W-1:0] sr;
        logic                   req_s1;
        logic                   req_s2;
        logic                   ack;
        logic                   edge_tog;
    } ldfcl_link_st_t;

    ldfcl_link_st_t link_reg;
    ldfcl_link_st_t link_next;

    // ============================================================
    // Shift path
    // The serial clock stands still between frames, so a status
    // load cannot happen at the strobe itself: it is applied on the
    // first edge at which the synchronised request is seen.
    always_comb
    begin
        link_next          = link_reg;
        link_next.req_s1   = load_toggle;
        link_next.req_s2   = link_reg.req_s1;
        link_next.edge_tog = ~link_reg.edge_tog;
        if (link_reg.req_s2 != link_reg.ack)
        begin
            link_next.sr  = {1'b0, load_word};
            link_next.ack = link_reg.req_s2;
        end
        else
        begin
            link_next.sr = {link_reg.sr[`LDFCL_SR_W-2:0],
                            serial_input};
        end
    end

    always_ff @(posedge serial_clock)
    begin
        if (!rst_b)
        begin
            link_reg    <= '0;
            link_reg.sr <= `LDFCL_SR_RESET;
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    assign shift_word    = link_reg.sr;
    assign serial_output = link_reg.sr[`LDFCL_SEL_BIT];
    assign edge_toggle   = link_reg.edge_tog;

endmodule

// ===== rtl/ldfcl_idm_timer.sv
`timescale 1ns/100ps

`include "ldfcl_params.svh"

module ldfcl_idm_timer
    import ldfcl_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic [1:0] duration,
    output logic            busy,
    output logic            done
);

    typedef struct packed {
        ldfcl_idm_state_t         state;
        logic [`LDFCL_CNT_W-1:0]  count;
        logic                     busy;
        logic                     done;
    } ldfcl_idm_st_t;

    ldfcl_idm_st_t tmr_reg;
    ldfcl_idm_st_t tmr_next;

    function automatic logic [`LDFCL_CNT_W-1:0] on_periods(
        input logic [1:0] code
    );
        case (code)
            2'h0:    on_periods = `LDFCL_IDM_T0;
            2'h1:    on_periods = `LDFCL_IDM_T1;
            2'h2:    on_periods = `LDFCL_IDM_T2;
            default: on_periods = `LDFCL_IDM_T3;
        endcase
    endfunction

    // ============================================================
    // On-time counter, one step per timebase period
    always_comb
    begin
        tmr_next      = tmr_reg;
        tmr_next.done = 1'b0;
        case (tmr_reg.state)
            LDFCL_IDM_IDLE:
            begin
                if (start)
                begin
                    tmr_next.count = on_periods(duration);
                    tmr_next.state = LDFCL_IDM_RUN;
                end
            end
            LDFCL_IDM_RUN:
            begin
                if (tmr_reg.count == `LDFCL_CNT_LAST)
                begin
                    tmr_next.state = LDFCL_IDM_IDLE;
                    tmr_next.done  = 1'b1;
                end
                tmr_next.count = tmr_reg.count - `LDFCL_CNT_LAST;
            end
            default:
            begin
                tmr_next.state = LDFCL_IDM_IDLE;
            end
        endcase
        tmr_next.busy = (tmr_next.state == LDFCL_IDM_RUN);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            tmr_reg       <= '0;
            tmr_reg.state <= LDFCL_IDM_IDLE;
        end
        else
        begin
            tmr_reg <= tmr_next;
        end
    end

    assign busy = tmr_reg.busy;
    assign done = tmr_reg.done;

endmodule

// ===== verification/ldfcl_host_model.sv
`timescale 1ns/100ps

module ldfcl_host_model (
    output logic      serial_clock,
    output logic      serial_input,
    output logic      latch_strobe,
    input  wire logic serial_output
);
    // ==========
    // Link starts low; the clock idles low between frames
    initial
    begin
        serial_clock = 1'b0;
        serial_input = 1'b0;
        latch_strobe = 1'b0;
    end

    // ==========
    // Shift n bits of w, top first; rd gathers serial_output before each rise
    task automatic shift(input logic [31:0] w, input int n,
                         output logic [31:0] rd);
        rd = 32'h0;
        for (int k = n - 1; k >= 0; k--)
        begin
            serial_input = w[k];
            #7.5;
            rd = {rd[30:0], serial_output};
            serial_clock = 1'b1;
            #7.5;
            serial_clock = 1'b0;
        end
        // Released line shows the inverse so a stale level cannot pass
        serial_input = ~serial_input;
    endtask

    // Strobe only once the whole word is in; link stays still meanwhile
    task automatic strobe();
        #40;
        latch_strobe = 1'b1;
        #100;
        latch_strobe = 1'b0;
        #100;
    endtask
endmodule

// ===== verification/ldfcl_core_asserts.sv
`timescale 1ns/100ps

module ldfcl_core_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        serial_clock,
    input wire logic        serial_input,
    input wire logic        serial_output,
    input wire logic        latch_strobe,
    input wire logic        blanking,
    input wire logic [15:0] open_led_flag,
    input wire logic [15:0] shorted_led_flag,
    input wire logic [15:0] output_leakage_flag,
    input wire logic        thermal_error_flag,
    input wire logic        prethermal_warning,
    input wire logic        ref_pin_short_flag,
    input wire logic [15:0] sink_channel,
    input wire logic [6:0]  global_brightness_code,
    input wire logic [1:0]  short_threshold_select,
    input wire logic [1:0]  invisible_detect_current,
    input wire logic        invisible_detection,
    input wire logic        power_save
);
    // ==========
    // Helpers: link activity seen as a toggle, on-time run length
    logic       sc_tog = 1'b0;
    logic [7:0] run_cnt;

    always_ff @(posedge serial_clock)
        sc_tog <= ~sc_tog;

    always_ff @(posedge ref_clk)
        if (!rst_b || !invisible_detection)
            run_cnt <= 8'h00;
        else
            run_cnt <= run_cnt + 8'h01;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ==========
    // Properties
    property p_blank_off;
        blanking [*5] |-> sink_channel == 16'h0000;
    endproperty
    a_blank_off: assert property (p_blank_off)
        else $error("channel lit while blanked");

    property p_ps_zero;
        $rose(power_save) |=> sink_channel == 16'h0000;
    endproperty
    a_ps_zero: assert property (p_ps_zero)
        else $error("power save with channels on");

    property p_ps_strobe;
        $rose(power_save) |-> $past(latch_strobe, 2);
    endproperty
    a_ps_strobe: assert property (p_ps_strobe)
        else $error("power save entered without strobe");

    property p_ps_exit;
        power_save && $changed(sc_tog) |-> ##[1:5] !power_save;
    endproperty
    a_ps_exit: assert property (p_ps_exit)
        else $error("power save kept after link clock");

    property p_fields_hold;
        !$stable({global_brightness_code, short_threshold_select,
                  invisible_detect_current}) |-> $past(latch_strobe, 2);
    endproperty
    a_fields_hold: assert property (p_fields_hold)
        else $error("function fields moved without strobe");

    property p_idm_cur;
        $rose(invisible_detection) |-> invisible_detect_current != 2'h0;
    endproperty
    a_idm_cur: assert property (p_idm_cur)
        else $error("detection with current disabled");

    property p_idm_cause;
        $rose(invisible_detection) |-> $past(blanking, 3);
    endproperty
    a_idm_cause: assert property (p_idm_cause)
        else $error("detection without blanking");

    property p_idm_len;
        $fell(invisible_detection) |->
            run_cnt inside {8'h11, 8'h21, 8'h41, 8'h81};
    endproperty
    a_idm_len: assert property (p_idm_len)
        else $error("detection on-time length wrong");
endmodule

bind ldfcl_core ldfcl_core_asserts u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .serial_clock(serial_clock),
    .serial_input(serial_input), .serial_output(serial_output),
    .latch_strobe(latch_strobe), .blanking(blanking),
    .open_led_flag(open_led_flag), .shorted_led_flag(shorted_led_flag),
    .output_leakage_flag(output_leakage_flag),
    .thermal_error_flag(thermal_error_flag),
    .prethermal_warning(prethermal_warning),
    .ref_pin_short_flag(ref_pin_short_flag), .sink_channel(sink_channel),
    .global_brightness_code(global_brightness_code),
    .short_threshold_select(short_threshold_select),
    .invisible_detect_current(invisible_detect_current),
    .invisible_detection(invisible_detection), .power_save(power_save)
);

// ===== verification/led_driver_function_control_latch_test.sv
`timescale 1ns/100ps

module led_driver_function_control_latch_test;
    logic        ref_clk = 1'b0;
    logic        rst_b, blanking, serial_clock, serial_input, serial_output;
    logic        latch_strobe, thermal_error_flag, prethermal_warning;
    logic        ref_pin_short_flag, invisible_detection, power_save;
    logic [15:0] open_led_flag, shorted_led_flag, output_leakage_flag;
    logic [15:0] sink_channel;
    logic [6:0]  global_brightness_code;
    logic [1:0]  short_threshold_select, invisible_detect_current;
    logic [31:0] seed = 32'h0000005d;
    int          fail_count = 0;
    int          cmp_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    ldfcl_core dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .serial_clock(serial_clock),
        .serial_input(serial_input), .serial_output(serial_output),
        .latch_strobe(latch_strobe), .blanking(blanking),
        .open_led_flag(open_led_flag), .shorted_led_flag(shorted_led_flag),
        .output_leakage_flag(output_leakage_flag),
        .thermal_error_flag(thermal_error_flag),
        .prethermal_warning(prethermal_warning),
        .ref_pin_short_flag(ref_pin_short_flag), .sink_channel(sink_channel),
        .global_brightness_code(global_brightness_code),
        .short_threshold_select(short_threshold_select),
        .invisible_detect_current(invisible_detect_current),
        .invisible_detection(invisible_detection), .power_save(power_save)
    );

    ldfcl_host_model host (
        .serial_clock(serial_clock), .serial_input(serial_input),
        .latch_strobe(latch_strobe), .serial_output(serial_output)
    );

    // ==========
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Alarm flag overrides the per-channel word with all ones
    function automatic logic [15:0] status_exp(input logic [1:0] sel);
        case (sel)
            2'h1: return thermal_error_flag ? 16'hffff : open_led_flag;
            2'h2: return prethermal_warning ? 16'hffff : shorted_led_flag;
            default: return ref_pin_short_flag ? 16'hffff
                                               : output_leakage_flag;
        endcase
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        fail_count++;
        give_verdict();
    end

    // ==========
    // Main sequence
    initial
    begin
        logic [31:0] r, rd;
        logic [15:0] d, fc;
        int          n;
        rst_b = 1'b0;
        blanking = 1'b0;
        {thermal_error_flag, prethermal_warning, ref_pin_short_flag} = 3'h0;
        {open_led_flag, shorted_led_flag, output_leakage_flag} = 48'h0;
        host.shift(32'h0, 4, rd);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("defaults", {7'h7f, 2'h3, 2'h0},
            {global_brightness_code, short_threshold_select,
             invisible_detect_current});
        chk("ps_serial_output_reset", 32'h0, {power_save, serial_output});
        chk("sink_reset", 32'h0, sink_channel);
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            open_led_flag = r[15:0];
            shorted_led_flag = r[31:16];
            r = rnd();
            output_leakage_flag = r[15:0];
            // Later tests raise every alarm so the all-ones path is read
            {thermal_error_flag, prethermal_warning, ref_pin_short_flag} =
                (r[18:16] & r[21:19]) | {3{i[2]}};
            r = rnd();
            d = i[0] ? 16'h0000 : r[31:16];
            fc = {~i[1], i[2:1], 2'(1 + i % 3), r[10:9], i[1:0], r[6:0]};
            host.shift({15'h0, 1'b1, fc}, 17, rd);
            host.strobe();
            @(negedge ref_clk);
            chk("brightness", fc[6:0], global_brightness_code);
            chk("threshold", fc[10:9], short_threshold_select);
            chk("det_current", fc[12:11], invisible_detect_current);
            host.shift(32'h0, 17, rd);
            chk("fc_echo", {1'b1, fc}, rd);
            host.shift({16'h0, d}, 17, rd);
            host.strobe();
            @(negedge ref_clk);
            chk("sink", d, sink_channel);
            chk("power_save", d == 16'h0 && fc[15], power_save);
            host.shift(32'h0, 20, rd);
            chk("status", {1'b0, fc[8:7] != 2'h0 ? status_exp(fc[8:7]) : d},
                fc[8:7] != 2'h0 ? rd[16:0] : rd[19:3]);
            repeat (6) @(negedge ref_clk);
            chk("ps_exit", 32'h0, power_save);
            blanking = 1'b1;
            n = 0;
            for (int k = 0; k < 20 && invisible_detection !== 1'b1; k++)
                @(negedge ref_clk);
            while (invisible_detection === 1'b1 && n < 300)
            begin
                @(negedge ref_clk);
                n++;
            end
            chk("idm_len", (16 << fc[14:13]) + 1, n);
            chk("blank_sink", 32'h0, sink_channel);
            blanking = 1'b0;
            repeat (5) @(negedge ref_clk);
            chk("unblank", d, sink_channel);
            $display("test %0d done", i);
        end
        give_verdict();
    end
endmodule
